// File: design/fwh_pkg.sv
// Constants, register map and carrier types of the flash write/status host controller.
// Assumes a single 40 MHz clock domain and an asynchronous parallel flash on the pins.
package fwh_pkg;

	// ----------------------------------------------------------------
	// Clock rate and flash timing, figures in their own units
	// ----------------------------------------------------------------
	localparam int CLK_MHZ    = 40;
	localparam int T_WP_NS    = 60;   // Write or chip select pulse width, slowest grade
	localparam int T_WPH_NS   = 30;   // Strobe high time between write cycles
	localparam int T_ACC_NS   = 120;  // Read access, slowest grade
	localparam int T_OEH_NS   = 30;   // Output enable hold for toggle and polling reads
	localparam int T_BUSY_NS  = 200;  // Command valid to ready/busy valid
	localparam int T_RP_NS    = 500;  // Hardware reset pulse width
	localparam int T_RSP_US   = 4;    // Elevated reset voltage setup before a write
	localparam int T_READY_US = 20;   // Reset during an embedded algorithm to access

	// Least times round up to whole cycles
	localparam int C_WP    = (T_WP_NS * CLK_MHZ + 999) / 1000;
	localparam int C_WPH   = (T_WPH_NS * CLK_MHZ + 999) / 1000;
	localparam int C_ACC   = (T_ACC_NS * CLK_MHZ + 999) / 1000;
	localparam int C_OEH   = (T_OEH_NS * CLK_MHZ + 999) / 1000;
	localparam int C_BUSY  = (T_BUSY_NS * CLK_MHZ + 999) / 1000;
	localparam int C_RP    = (T_RP_NS * CLK_MHZ + 999) / 1000;
	localparam int C_RSP   = T_RSP_US * CLK_MHZ;
	localparam int C_READY = T_READY_US * CLK_MHZ;
	localparam int C_SYNC  = 2;       // Extra read strobe cycles to cover the data synchroniser

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CMD      = 8'h00;
	localparam logic [7:0] REG_CFG      = 8'h04;
	localparam logic [7:0] REG_ADDR     = 8'h08;
	localparam logic [7:0] REG_WDATA    = 8'h0c;
	localparam logic [7:0] REG_RDATA    = 8'h10;
	localparam logic [7:0] REG_STATUS   = 8'h14;
	localparam logic [7:0] REG_INT_STAT = 8'h18;
	localparam logic [7:0] REG_INT_MASK = 8'h1c;

	// Command bits, write-only pulses
	localparam int CMD_WRITE = 0;
	localparam int CMD_READ  = 1;
	localparam int CMD_RESET = 2;

	// Configuration fields
	localparam int         CFG_WAIT   = 0;   // Poll for completion after a write
	localparam int         CFG_POLL   = 1;   // Two bits: completion method
	localparam int         CFG_CE_WR  = 3;   // Writes strobed by chip select
	localparam int         CFG_CE_RD  = 4;   // Reads strobed by chip select
	localparam int         CFG_VID    = 5;   // Request elevated voltage on reset pin
	localparam int         CFG_PROT   = 6;   // Two bits: protect address forcing
	localparam logic [7:0] CFG_RST    = 8'h00;

	localparam logic [1:0] POLL_TOGGLE = 2'h0;
	localparam logic [1:0] POLL_DATA   = 2'h1;
	localparam logic [1:0] PROT_ON     = 2'h1;
	localparam logic [1:0] PROT_OFF    = 2'h2;

	// Status bits
	localparam int ST_BUSY     = 0;
	localparam int ST_VID_OK   = 1;
	localparam int ST_READY    = 2;
	localparam int ST_TOG_SEEN = 3;
	localparam int ST_SUS_SEEN = 4;

	// Interrupt bits
	localparam int         IRQ_W    = 3;
	localparam int         IRQ_DONE = 0;
	localparam int         IRQ_RD   = 1;
	localparam int         IRQ_RST  = 2;
	localparam logic [2:0] IRQ_RST_VAL = 3'h0;

	// Flash status bit positions and protect address bits
	localparam int POLL_BIT = 7;
	localparam int TOG_BIT  = 6;
	localparam int SUS_BIT  = 2;
	localparam int PROT_A6  = 6;
	localparam int PROT_A1  = 1;
	localparam int PROT_A0  = 0;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic oe_n;
	} fwh_strobe_t;

	typedef struct packed {
		logic write;
		logic ce_strobe;
	} fwh_req_t;

	localparam fwh_strobe_t STRB_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};

endpackage

// File: design/fwh_cycle.sv
// One flash bus cycle, read or write, strobed by chip select or by write/output enable.
// Assumes the caller holds address and data only at start; pins are all registered.
`timescale 1ns/10ps
module fwh_cycle import fwh_pkg::*; #(
	parameter int ADDR_W = 18,
	parameter int DQ_W   = 16
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              start,
	input  wire fwh_req_t          req,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DQ_W-1:0]   wdata,
	output logic                   done,
	output logic [DQ_W-1:0]        rdata,
	output logic [ADDR_W-1:0]      fl_addr,
	output logic [DQ_W-1:0]        fl_dq_o,
	output logic                   fl_dq_oe_n,
	input  wire logic [DQ_W-1:0]   fl_dq_i,
	output fwh_strobe_t            strb
);

	typedef enum logic [2:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD, C_RECOV} fwh_cyc_t;

	fwh_cyc_t    state_reg;
	fwh_cyc_t    state_next;
	logic [7:0]  cnt_reg;
	fwh_req_t    req_reg;
	fwh_req_t    mode;
	fwh_strobe_t strb_next;
	logic        take;
	logic        qual;
	logic        pulse;
	logic [DQ_W-1:0] dq_s1;
	logic [DQ_W-1:0] dq_s2;

	assign done = (state_reg == C_RECOV) && (cnt_reg == 8'h00);
	assign take = start && ((state_reg == C_IDLE) || done);
	assign mode = take ? req : req_reg;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			C_IDLE:   if (take) state_next = C_SETUP;
			C_SETUP:  state_next = C_STROBE;
			C_STROBE: if (cnt_reg == 8'h00) state_next = C_HOLD;
			C_HOLD:   state_next = C_RECOV;
			C_RECOV:  if (done) state_next = take ? C_SETUP : C_IDLE;
			default:  state_next = C_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) state_reg <= C_IDLE;
		else     state_reg <= state_next;
	end

	// Strobe and recovery lengths; reads stretch to cover the synchroniser
	always_ff @(posedge clk) begin
		if (rst)
			cnt_reg <= 8'h00;
		else if (state_reg == C_SETUP)
			cnt_reg <= req_reg.write ? 8'(C_WP - 1) : 8'(C_ACC + C_SYNC - 1);
		else if (state_reg == C_HOLD)
			cnt_reg <= req_reg.write ? 8'(C_WPH - 1) : 8'(C_OEH - 1);
		else if (cnt_reg != 8'h00)
			cnt_reg <= cnt_reg - 8'h01;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			req_reg <= '0;
			fl_addr <= '0;
			fl_dq_o <= '0;
		end else if (take) begin
			req_reg <= req;
			fl_addr <= addr;
			fl_dq_o <= wdata;
		end
	end

	// ----------------------------------------------------------------
	// Pin drive: qualifier held around the strobe pulse
	// ----------------------------------------------------------------
	always_comb begin
		qual      = (state_next == C_SETUP) || (state_next == C_STROBE) || (state_next == C_HOLD);
		pulse     = (state_next == C_STROBE);
		strb_next = STRB_IDLE;
		if (mode.write && mode.ce_strobe) begin
			strb_next.we_n = !qual;
			strb_next.ce_n = !pulse;
		end else if (mode.write) begin
			strb_next.ce_n = !qual;
			strb_next.we_n = !pulse;
		end else if (mode.ce_strobe) begin
			strb_next.oe_n = !qual;
			strb_next.ce_n = !pulse;
		end else begin
			strb_next.ce_n = !qual;
			strb_next.oe_n = !pulse;
		end
	end

	// Registered pins keep glitches off the flash strobes
	always_ff @(posedge clk) begin
		if (rst) begin
			strb       <= STRB_IDLE;
			fl_dq_oe_n <= 1'b1;
		end else begin
			strb       <= strb_next;
			fl_dq_oe_n <= !(mode.write && qual);
		end
	end

	// Data pins come from another timing domain: two flops before use
	always_ff @(posedge clk) begin
		if (rst) begin
			dq_s1 <= '0;
			dq_s2 <= '0;
		end else begin
			dq_s1 <= fl_dq_i;
			dq_s2 <= dq_s1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			rdata <= '0;
		else if ((state_reg == C_STROBE) && (cnt_reg == 8'h00) && !req_reg.write)
			rdata <= dq_s2;
	end

endmodule

// File: design/fwh_host.sv
// Host controller for an asynchronous parallel flash: write cycles, status polling, reset.
// Assumes software sequences the command cycles; an external switch makes the raised reset level.
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module fwh_host import fwh_pkg::*; #(
	parameter int ADDR_W = 18,
	parameter int DQ_W   = 16
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata,
	output logic                   irq,
	output logic [ADDR_W-1:0]      fl_addr,
	output logic [DQ_W-1:0]        fl_dq_o,
	output logic                   fl_dq_oe_n,
	input  wire logic [DQ_W-1:0]   fl_dq_i,
	output logic                   fl_ce_n,
	output logic                   fl_we_n,
	output logic                   fl_oe_n,
	output logic                   fl_reset_n,
	output logic                   fl_vid_en,
	input  wire logic              fl_ready_busy
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (ADDR_W < 7 || ADDR_W > 32) begin : g_chk_addr
		$error("ADDR_W must lie in 7..32");
	end
	if (DQ_W < 8 || DQ_W > 32) begin : g_chk_dq
		$error("DQ_W must lie in 8..32");
	end

	typedef enum logic [3:0] {
		S_IDLE, S_VIDW, S_WR, S_TBUSY, S_POLL, S_RB, S_RD, S_RST_LOW, S_RST_WAIT
	} fwh_state_t;

	fwh_state_t        state_reg;
	fwh_state_t        state_next;
	logic [9:0]        cnt_reg;
	logic [7:0]        cfg_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [DQ_W-1:0]   wdata_reg;
	logic [DQ_W-1:0]   rdata_reg;
	logic [DQ_W-1:0]   last_reg;
	logic              first_reg;
	logic              tog_seen_reg;
	logic              sus_seen_reg;
	logic [7:0]        vid_cnt_reg;
	logic              rb_s1;
	logic              rb_s2;
	logic [IRQ_W-1:0]  int_stat_reg;
	logic [IRQ_W-1:0]  int_mask_reg;
	logic [IRQ_W-1:0]  ev;
	logic [ADDR_W-1:0] eff_addr;
	logic              cmd_wr;
	logic              cmd_rd;
	logic              cmd_rst;
	logic              vid_ok;
	logic              poll_ok;
	logic              cyc_start;
	logic              cyc_write;
	logic              cyc_done;
	logic [DQ_W-1:0]   cyc_rdata;
	fwh_req_t          cyc_req;
	fwh_strobe_t       strb;

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	assign cmd_wr  = reg_wr && (reg_addr == REG_CMD) && reg_wdata[CMD_WRITE];
	assign cmd_rd  = reg_wr && (reg_addr == REG_CMD) && reg_wdata[CMD_READ];
	assign cmd_rst = reg_wr && (reg_addr == REG_CMD) && reg_wdata[CMD_RESET];

	// Settings; strobe mode, protect forcing, address and pin write data changed mid operation take effect on the next cycle started, the others at once
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_reg      <= CFG_RST;
			addr_reg     <= '0;
			wdata_reg    <= '0;
			int_mask_reg <= IRQ_RST_VAL;
		end else if (reg_wr) begin
			case (reg_addr)
				REG_CFG:      cfg_reg      <= reg_wdata[7:0];
				REG_ADDR:     addr_reg     <= reg_wdata[ADDR_W-1:0];
				REG_WDATA:    wdata_reg    <= reg_wdata[DQ_W-1:0];
				REG_INT_MASK: int_mask_reg <= reg_wdata[IRQ_W-1:0];
				default:      ;
			endcase
		end
	end

	// Read data one cycle after the strobe; unmapped offsets read zero
	always_ff @(posedge clk) begin
		if (rst)
			reg_rdata <= 32'h0;
		else if (reg_rd) begin
			case (reg_addr)
				REG_CFG:      reg_rdata <= {24'h0, cfg_reg};
				REG_ADDR:     reg_rdata <= 32'(addr_reg);
				REG_WDATA:    reg_rdata <= 32'(wdata_reg);
				REG_RDATA:    reg_rdata <= 32'(rdata_reg);
				REG_STATUS:   reg_rdata <= {27'h0, sus_seen_reg, tog_seen_reg, rb_s2, vid_ok,
				                            (state_reg != S_IDLE)};
				REG_INT_STAT: reg_rdata <= 32'(int_stat_reg);
				REG_INT_MASK: reg_rdata <= 32'(int_mask_reg);
				default:      reg_rdata <= 32'h0;
			endcase
		end else
			reg_rdata <= 32'h0;
	end

	// Sticky events; a new event beats a clear in the same cycle
	always_ff @(posedge clk) begin
		if (rst)
			int_stat_reg <= IRQ_RST_VAL;
		else if (reg_wr && (reg_addr == REG_INT_STAT))
			int_stat_reg <= (int_stat_reg & ~reg_wdata[IRQ_W-1:0]) | ev;
		else
			int_stat_reg <= int_stat_reg | ev;
	end

	assign irq = |(int_stat_reg & int_mask_reg);

	// ----------------------------------------------------------------
	// Pin inputs and raised reset voltage
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			rb_s1 <= 1'b1; // Idle level of the pin, so no false busy after reset
			rb_s2 <= 1'b1;
		end else begin
			rb_s1 <= fl_ready_busy;
			rb_s2 <= rb_s1;
		end
	end

	// Setup time restarts whenever the request drops or a reset pulse runs
	always_ff @(posedge clk) begin
		if (rst || !cfg_reg[CFG_VID] || state_reg == S_RST_LOW)
			vid_cnt_reg <= 8'h00;
		else if (vid_cnt_reg != 8'(C_RSP))
			vid_cnt_reg <= vid_cnt_reg + 8'h01;
	end

	assign vid_ok = (vid_cnt_reg == 8'(C_RSP));

	always_ff @(posedge clk) begin
		if (rst) begin
			fl_vid_en  <= 1'b0;
			fl_reset_n <= 1'b1;
		end else begin
			fl_vid_en  <= cfg_reg[CFG_VID] && (state_next != S_RST_LOW);
			fl_reset_n <= (state_next != S_RST_LOW);
		end
	end

	// Protect address pattern overrides three address bits
	always_comb begin
		eff_addr = addr_reg;
		if (cfg_reg[CFG_PROT+1:CFG_PROT] == PROT_ON) begin
			eff_addr[PROT_A6] = 1'b0;
			eff_addr[PROT_A1] = 1'b1;
			eff_addr[PROT_A0] = 1'b0;
		end else if (cfg_reg[CFG_PROT+1:CFG_PROT] == PROT_OFF) begin
			eff_addr[PROT_A6] = 1'b1;
			eff_addr[PROT_A1] = 1'b1;
			eff_addr[PROT_A0] = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Completion test
	// ----------------------------------------------------------------
	always_comb begin
		if (cfg_reg[CFG_POLL+1:CFG_POLL] == POLL_DATA)
			poll_ok = (cyc_rdata[POLL_BIT] == wdata_reg[POLL_BIT]);
		else
			poll_ok = !first_reg && (cyc_rdata[TOG_BIT] == last_reg[TOG_BIT]);
	end

	// ----------------------------------------------------------------
	// Operation sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		cyc_start  = 1'b0;
		cyc_write  = 1'b0;
		ev         = '0;
		case (state_reg)
			S_IDLE: begin
				if (cmd_rst)
					state_next = S_RST_LOW;
				else if (cmd_wr && cfg_reg[CFG_VID] && !vid_ok)
					state_next = S_VIDW;
				else if (cmd_wr) begin
					cyc_start  = 1'b1;
					cyc_write  = 1'b1;
					state_next = S_WR;
				end else if (cmd_rd) begin
					cyc_start  = 1'b1;
					state_next = S_RD;
				end
			end
			S_VIDW: begin
				if (vid_ok) begin
					cyc_start  = 1'b1;
					cyc_write  = 1'b1;
					state_next = S_WR;
				end
			end
			S_WR: begin
				if (cyc_done && cfg_reg[CFG_WAIT])
					state_next = S_TBUSY;
				else if (cyc_done) begin
					ev[IRQ_DONE] = 1'b1;
					state_next   = S_IDLE;
				end
			end
			S_TBUSY: begin
				// Ready/busy means nothing until its delay has passed
				if (cnt_reg == 10'h000 && cfg_reg[CFG_POLL+1])
					state_next = S_RB;
				else if (cnt_reg == 10'h000) begin
					cyc_start  = 1'b1;
					state_next = S_POLL;
				end
			end
			S_POLL: begin
				if (cyc_done && poll_ok) begin
					ev[IRQ_DONE] = 1'b1;
					state_next   = S_IDLE;
				end else if (cyc_done)
					cyc_start = 1'b1;
			end
			S_RB: begin
				if (rb_s2) begin
					ev[IRQ_DONE] = 1'b1;
					state_next   = S_IDLE;
				end
			end
			S_RD: begin
				if (cyc_done) begin
					ev[IRQ_RD] = 1'b1;
					state_next = S_IDLE;
				end
			end
			S_RST_LOW:  if (cnt_reg == 10'h000) state_next = S_RST_WAIT;
			S_RST_WAIT: begin
				if (cnt_reg == 10'h000) begin
					ev[IRQ_RST] = 1'b1;
					state_next  = S_IDLE;
				end
			end
			default: state_next = S_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) state_reg <= S_IDLE;
		else     state_reg <= state_next;
	end

	// Wait counter loaded on entry to each timed state
	always_ff @(posedge clk) begin
		if (rst)
			cnt_reg <= 10'h000;
		else if (state_next != state_reg) begin
			case (state_next)
				S_TBUSY:    cnt_reg <= 10'(C_BUSY - 1);
				S_RST_LOW:  cnt_reg <= 10'(C_RP - 1);
				S_RST_WAIT: cnt_reg <= 10'(C_READY - 1);
				default:    cnt_reg <= 10'h000;
			endcase
		end else if (cnt_reg != 10'h000)
			cnt_reg <= cnt_reg - 10'h001;
	end

	// Read history: toggle bits compared between successive reads
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_reg    <= '0;
			last_reg     <= '0;
			first_reg    <= 1'b1;
			tog_seen_reg <= 1'b0;
			sus_seen_reg <= 1'b0;
		end else if (cyc_done && (state_reg == S_POLL || state_reg == S_RD)) begin
			rdata_reg    <= cyc_rdata;
			last_reg     <= cyc_rdata;
			first_reg    <= 1'b0;
			tog_seen_reg <= cyc_rdata[TOG_BIT] ^ last_reg[TOG_BIT];
			sus_seen_reg <= cyc_rdata[SUS_BIT] ^ last_reg[SUS_BIT];
		end else if (state_next == S_TBUSY)
			first_reg <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Bus cycle engine
	// ----------------------------------------------------------------
	assign cyc_req.write     = cyc_write;
	assign cyc_req.ce_strobe = cyc_write ? cfg_reg[CFG_CE_WR] : cfg_reg[CFG_CE_RD];

	fwh_cycle #(
		.ADDR_W (ADDR_W),
		.DQ_W   (DQ_W)
	) u_cycle (
		.clk        (clk),
		.rst        (rst),
		.start      (cyc_start),
		.req        (cyc_req),
		.addr       (eff_addr),
		.wdata      (wdata_reg),
		.done       (cyc_done),
		.rdata      (cyc_rdata),
		.fl_addr    (fl_addr),
		.fl_dq_o    (fl_dq_o),
		.fl_dq_oe_n (fl_dq_oe_n),
		.fl_dq_i    (fl_dq_i),
		.strb       (strb)
	);

	assign fl_ce_n = strb.ce_n;
	assign fl_we_n = strb.we_n;
	assign fl_oe_n = strb.oe_n;

endmodule

// File: dv/fwh_host_chk.sv
// Port assertions for the flash host controller.
// Assumes the package map; CFG is written only while idle.
`timescale 1ns/10ps
module fwh_host_chk import fwh_pkg::*; #(
	parameter int ADDR_W = 18
) (
	input wire logic              clk,
	input wire logic              rst,
	input wire logic [7:0]        reg_addr,
	input wire logic [31:0]       reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [31:0]       reg_rdata,
	input wire logic              irq,
	input wire logic [ADDR_W-1:0] fl_addr,
	input wire logic              fl_dq_oe_n,
	input wire logic              fl_ce_n,
	input wire logic              fl_we_n,
	input wire logic              fl_oe_n,
	input wire logic              fl_vid_en
);
	logic [7:0] cfg_reg;
	logic [7:0] vid_cnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Mirror of the mode bits, so checks know the mode
	always_ff @(posedge clk) begin
		if (rst)
			cfg_reg <= 8'h00;
		else if (reg_wr && reg_addr == REG_CFG)
			cfg_reg <= reg_wdata[7:0];
	end
	// Cycles the raised level has stood; saturates
	always_ff @(posedge clk) begin
		if (rst || !fl_vid_en)
			vid_cnt <= 8'h00;
		else if (vid_cnt != 8'hff)
			vid_cnt <= vid_cnt + 8'h01;
	end

	// ----
	// Checks
	// ----
	chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("rdata not zero");
	chk_irq_masked: assert property (reg_wr && reg_addr == REG_INT_MASK && reg_wdata[2:0] == 3'h0 |=> !irq)
		else $error("irq while masked");
	chk_we_width: assert property ($fell(fl_we_n) && !fl_ce_n |-> !fl_we_n[*3] ##1 fl_we_n)
		else $error("we pulse width");
	chk_ce_width: assert property ($fell(fl_ce_n) && !fl_we_n |-> !fl_ce_n[*3] ##1 fl_ce_n)
		else $error("ce pulse width");
	chk_write_drive: assert property (!fl_we_n |-> fl_oe_n && !fl_dq_oe_n)
		else $error("write without data");
	chk_read_release: assert property (!fl_oe_n |-> fl_dq_oe_n) else $error("bus clash on read");
	chk_prot_addr: assert property (!fl_ce_n && cfg_reg[7:6] == PROT_ON |->
		!fl_addr[PROT_A6] && fl_addr[PROT_A1] && !fl_addr[PROT_A0]) else $error("protect pattern");
	chk_unprot_addr: assert property (!fl_ce_n && cfg_reg[7:6] == PROT_OFF |->
		fl_addr[PROT_A6] && fl_addr[PROT_A1] && !fl_addr[PROT_A0]) else $error("unprotect pattern");
	chk_poll_gap: assert property (cfg_reg[CFG_WAIT] && $rose(fl_we_n) |-> fl_oe_n[*8])
		else $error("poll too early");
	chk_vid_setup: assert property (fl_vid_en && !fl_we_n |-> vid_cnt >= 8'ha0)
		else $error("write before setup");
endmodule

bind fwh_host fwh_host_chk #(.ADDR_W(ADDR_W)) chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
	.fl_addr(fl_addr), .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
	.fl_oe_n(fl_oe_n), .fl_vid_en(fl_vid_en));

// File: dv/fwh_flash_model.sv
// Behavioural flash: one program target, status bits, ready/busy, reset abort.
// Assumes strobes settle before each falling clock edge.
`timescale 1ns/10ps
module fwh_flash_model #(
	parameter int ADDR_W   = 18,
	parameter int DQ_W     = 16,
	parameter int PROG_CYC = 200,
	parameter int BUSY_CYC = 8,
	parameter int ERASE_CYC = 600,                  // Far shorter than a real sector erase, keeps the run short
	parameter logic [DQ_W-1:0] ERASE_KEY = 16'h5a5a // Written word standing in for an erase; value arbitrary
) (
	input  wire logic              clk,
	input  wire logic              ce_n,
	input  wire logic              we_n,
	input  wire logic              oe_n,
	input  wire logic              reset_n,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DQ_W-1:0]   dq_i,
	output logic [DQ_W-1:0]        dq_o,
	output logic                   ready_busy,
	output logic [ADDR_W-1:0]      last_addr,
	output logic [DQ_W-1:0]        last_data
);
	logic            busy = 1'b0;
	logic            tog  = 1'b0;
	logic            wr_q = 1'b0;
	logic            rd_q = 1'b0;
	logic            erasing = 1'b0;
	logic [DQ_W-1:0] held = '0;
	int              cnt  = 0;
	wire             wr_on = !ce_n && !we_n;
	wire             rd_on = !ce_n && !oe_n;

	initial begin
		ready_busy = 1'b1;
		last_addr = '0;
		last_data = '0;
	end
	// Status while busy; bit 2 stays put, no sector is suspended
	always_comb begin
		dq_o = last_data;
		if (busy) begin
			dq_o[7] = ~last_data[7];
			dq_o[6] = tog;
		end
		if (!rd_on)
			dq_o = ~held;            // Released bus never shows the old value
	end
	// Mid-cycle sampling keeps clear of the launch edge
	always @(negedge clk) begin
		wr_q <= wr_on;
		rd_q <= rd_on;
		if (rd_on)
			held <= dq_o;
		if (busy && rd_q && !rd_on)
			tog <= ~tog;
		if (!reset_n) begin
			busy <= 1'b0;
			ready_busy <= 1'b1;
		end else if (wr_q && !wr_on && !busy) begin
			last_addr <= addr;
			last_data <= (dq_i == ERASE_KEY) ? '0 : dq_i; // Erase first programs the area to zeros
			erasing <= (dq_i == ERASE_KEY);
			busy <= 1'b1;
			cnt <= 0;
		end else if (busy) begin
			cnt <= cnt + 1;
			if (cnt == BUSY_CYC)
				ready_busy <= 1'b0;
			if (cnt == (erasing ? ERASE_CYC : PROG_CYC)) begin
				busy <= 1'b0;
				ready_busy <= 1'b1;
				if (erasing)
					last_data <= '1; // Erased cells read all ones
			end
		end
	end
endmodule

// File: dv/fwh_host_bench.sv
// Bench for the flash host controller against the flash model.
// Assumes the package register map and a 40 MHz clock.
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; $display("BAD %s %h %h", n, e, s); end end
module fwh_host_bench import fwh_pkg::*;;
	logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, mon_e;
	logic        irq, fl_dq_oe_n, fl_ce_n, fl_we_n, fl_oe_n, fl_reset_n, fl_vid_en, fl_ready_busy;
	logic [17:0] fl_addr, last_a;
	logic [15:0] fl_dq_o, fl_dq_i, mdl_o, last_d;
	logic [31:0] exp_q[$];
	int          bad_count = 0, comparisons = 0, seed = 68776;
	localparam logic [15:0] ERASE_KEY = 16'h5a5a; // Arbitrary stand-in erase word
	assign fl_dq_i = fl_dq_oe_n ? mdl_o : fl_dq_o;

	fwh_host #(.ADDR_W(18), .DQ_W(16)) dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe_n(fl_dq_oe_n), .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n),
		.fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_reset_n(fl_reset_n), .fl_vid_en(fl_vid_en),
		.fl_ready_busy(fl_ready_busy));
	fwh_flash_model #(.ADDR_W(18), .DQ_W(16), .ERASE_KEY(ERASE_KEY)) mdl_u (.clk(clk), .ce_n(fl_ce_n), .we_n(fl_we_n),
		.oe_n(fl_oe_n), .reset_n(fl_reset_n), .addr(fl_addr), .dq_i(fl_dq_i), .dq_o(mdl_o),
		.ready_busy(fl_ready_busy), .last_addr(last_a), .last_data(last_d));

	initial forever #12.5 clk = ~clk;

	// ----
	// Bus tasks; an idle cycle after each keeps strobes single-assigned
	// ----
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask
	// Start a command, wait for its interrupt, check and clear the cause
	task automatic op(input logic [2:0] cmd, input logic [31:0] cause);
		int n;
		n = 0;
		wr(REG_CMD, {29'h0, cmd});
		while (irq !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		`CHK("irq", 1'b1, irq)
		rd(REG_INT_STAT, cause);
		wr(REG_INT_STAT, cause);
		rd(REG_INT_STAT, 32'h0);
		`CHK("irq", 1'b0, irq)
	endtask
	task automatic final_report;
		if (bad_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Read data stand one cycle after the strobe; match with the oldest note
	always @(posedge clk) begin
		if (rd_d) begin
			mon_e = exp_q.pop_front();
			`CHK("reg_rdata", mon_e, reg_rdata)
		end
		rd_d <= reg_rd;
	end

	// Hang guard, far beyond the expected run
	initial begin
		#(25 * 40000);
		bad_count++;
		final_report();
	end

	initial begin
		logic [17:0] a, ea;
		logic [15:0] d, pd;
		logic [1:0]  prot;
		int          i;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(REG_CFG, 32'h0);
		rd(REG_STATUS, 32'h4);
		rd(REG_CMD, 32'h0);
		rd(8'hfc, 32'h0);
		wr(REG_INT_MASK, 32'h0);
		rd(REG_INT_MASK, 32'h0);
		wr(REG_INT_MASK, 32'h7);
		// Every poll mode, strobe choice and address forcing, random target
		for (i = 0; i < 6; i++) begin
			a = 18'($random(seed));
			d = 16'($random(seed));
			prot = 2'((i + 1) % 3);
			ea = a;
			if (prot != 2'h0) begin
				ea[6] = prot[1];
				ea[1] = 1'b1;
				ea[0] = 1'b0;
			end
			wr(REG_CFG, {24'h0, prot, i == 5, i[1], i[0], 2'(i % 3), 1'b1});
			wr(REG_ADDR, {14'h0, a});
			wr(REG_WDATA, {16'h0, d});
			op(3'h1, 32'h1);
			`CHK("addr", ea, last_a)
			`CHK("data", d, last_d)
			// Ready pin mode makes no status read, so the previous read stays in place
			rd(REG_RDATA, {16'h0, (i % 3 == 2) ? pd : d});
			op(3'h2, 32'h2);
			rd(REG_RDATA, {16'h0, d});
			pd = d;
		end
		op(3'h2, 32'h2);
		rd(REG_STATUS, 32'h6);
		// Stand-in erase; the command repeated inside op lands while busy and is ignored
		wr(REG_WDATA, {16'h0, ERASE_KEY});
		wr(REG_CMD, 32'h1);
		repeat (20) @(posedge clk);
		`CHK("zeros", 16'h0, last_d)
		op(3'h1, 32'h1);
		op(3'h2, 32'h2);
		rd(REG_RDATA, 32'h0000ffff);
		op(3'h4, 32'h4);
		repeat (3) @(posedge clk);
		final_report();
	end
endmodule
